// File: rtl/acgc_pkg.sv
// Constants, register map and types for the gain and chop configuration bank
package acgc_pkg;

  // Register word, address, code and decoded value widths, and channel count
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned MIN_AW   = 4;
  localparam int unsigned CODE_W   = 3;
  localparam int unsigned DLY_W    = 4;
  localparam int unsigned GAIN_W   = 8;
  localparam int unsigned PER_W    = 17;
  localparam int unsigned NUM_W    = 8;
  localparam int unsigned LEN_W    = 12;
  localparam int unsigned NUM_CH   = 2;

  // Register offsets, one word each
  localparam logic [3:0] OFS_GAIN = 4'h4;
  localparam logic [3:0] OFS_RSVD = 4'h5;
  localparam logic [3:0] OFS_CFG  = 4'h6;

  // Reset values
  localparam logic [15:0] RST_GAIN = 16'h0000;
  localparam logic [15:0] RST_RSVD = 16'h0000;
  localparam logic [15:0] RST_CFG  = 16'h0600;
  localparam logic [15:0] RD_ZERO  = 16'h0000;

  // Gain register field positions, channel n at n*GAIN_STEP
  localparam int unsigned GAIN0_LSB = 0;
  localparam int unsigned GAIN_STEP = 4;

  // Configuration word field positions
  localparam int unsigned DLY_LSB   = 9;
  localparam int unsigned CHOP_BIT  = 8;
  localparam int unsigned ALLCH_BIT = 7;
  localparam int unsigned NUM_LSB   = 4;
  localparam int unsigned LEN_LSB   = 1;
  localparam int unsigned CDEN_BIT  = 0;

  // Decode bases: each code step doubles from these; CNT_ONE is the settle count step
  localparam logic [GAIN_W-1:0] GAIN_BASE = 8'h01;
  localparam logic [PER_W-1:0]  DLY_BASE  = 17'h00002;
  localparam logic [NUM_W-1:0]  NUM_BASE  = 8'h01;
  localparam logic [PER_W-1:0]  CNT_ONE   = 17'h00001;

  // Measurement length in conversion periods, indexed by code
  localparam logic [7:0][LEN_W-1:0] LEN_TAB = {
    12'he00, 12'ha00, 12'h700, 12'h500,
    12'h300, 12'h200, 12'h100, 12'h080
  };

  // Chop settle sequencer states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_SETTLE = 2'b10
  } acgc_settle_e;

endpackage : acgc_pkg

// File: rtl/acgc_field_if.sv
// Field codes out of the register bank and their decoded values back
`timescale 1ns/1ns
`default_nettype none
interface acgc_field_if;
  logic [acgc_pkg::NUM_CH-1:0][acgc_pkg::CODE_W-1:0] gain_code;
  logic [acgc_pkg::NUM_CH-1:0][acgc_pkg::GAIN_W-1:0] gain;
  logic [acgc_pkg::DLY_W-1:0]  dly_code;
  logic [acgc_pkg::PER_W-1:0]  dly_periods;
  logic [acgc_pkg::CODE_W-1:0] num_code;
  logic [acgc_pkg::NUM_W-1:0]  num;
  logic [acgc_pkg::CODE_W-1:0] len_code;
  logic [acgc_pkg::LEN_W-1:0]  len;

  // Register side drives codes, decoder answers
  modport src (output gain_code, dly_code, num_code, len_code,
               input gain, dly_periods, num, len);
  modport dec (input gain_code, dly_code, num_code, len_code,
               output gain, dly_periods, num, len);
endinterface : acgc_field_if
`default_nettype wire

// File: rtl/acgc_field_dec.sv
// Decoder from configuration codes to gains, periods and counts
`timescale 1ns/1ns
`default_nettype none
module acgc_field_dec (
  acgc_field_if.dec fld
);

  // Per-channel power-of-two gain, 000b is 1 and 111b is 128
  for (genvar ch = 0; ch < acgc_pkg::NUM_CH; ch++) begin : g_gain
    assign fld.gain[ch] = acgc_pkg::GAIN_BASE << fld.gain_code[ch];
  end

  // Settle delay doubles per step from 2 up to 65536
  assign fld.dly_periods = acgc_pkg::DLY_BASE << fld.dly_code;

  // Exceedance count doubles per step from 1
  assign fld.num = acgc_pkg::NUM_BASE << fld.num_code;

  // Length steps are irregular, so a table
  assign fld.len = acgc_pkg::LEN_TAB[fld.len_code];

endmodule : acgc_field_dec
`default_nettype wire

// File: rtl/acgc_chop_settle.sv
// Chop settle sequencer: holds off measurement after each chop swap
`timescale 1ns/1ns
`default_nettype none
module acgc_chop_settle (
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  input  wire logic                        chop_en,
  input  wire logic [acgc_pkg::PER_W-1:0]  periods,
  input  wire logic                        mod_tick,
  input  wire logic                        chop_swap,
  output logic                             settling,
  output logic                             meas_resume
);

  typedef struct packed {
    acgc_pkg::acgc_settle_e      st;
    logic [acgc_pkg::PER_W-1:0]  cnt;
    logic                        busy;
    logic                        resume;
  } acgc_settle_s;

  acgc_settle_s s_q;
  acgc_settle_s s_d;

  // Count modulator ticks down; a new swap restarts the wait
  always_comb begin
    s_d        = s_q;
    s_d.resume = 1'b0;
    case (s_q.st)
      acgc_pkg::ST_IDLE: begin
        if (chop_en && chop_swap) begin
          s_d.st   = acgc_pkg::ST_SETTLE;
          s_d.cnt  = periods;
          s_d.busy = 1'b1;
        end
      end
      acgc_pkg::ST_SETTLE: begin
        if (!chop_en) begin
          s_d.st   = acgc_pkg::ST_IDLE;
          s_d.busy = 1'b0;
        end else if (chop_swap) begin
          s_d.cnt = periods;
        end else if (mod_tick) begin
          if (s_q.cnt == acgc_pkg::CNT_ONE) begin
            s_d.st     = acgc_pkg::ST_IDLE;
            s_d.busy   = 1'b0;
            s_d.resume = 1'b1;
          end else begin
            s_d.cnt = s_q.cnt - acgc_pkg::CNT_ONE;
          end
        end
      end
      default: begin
        s_d.st   = acgc_pkg::ST_IDLE;
        s_d.busy = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= '{st: acgc_pkg::ST_IDLE, cnt: '0, busy: 1'b0, resume: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign settling    = s_q.busy;
  assign meas_resume = s_q.resume;

endmodule : acgc_chop_settle
`default_nettype wire

// File: rtl/acgc_cfg_regs.sv
// Gain, reserved and configuration registers with decoded field outputs
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
`default_nettype none
module acgc_cfg_regs #(
  parameter int unsigned ADDR_W = 4
) (
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  // Register port
  input  wire logic [ADDR_W-1:0]           reg_addr,
  input  wire logic [acgc_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic [acgc_pkg::DATA_W-1:0]      reg_rdata,
  // Modulator timing
  input  wire logic                        mod_tick,
  input  wire logic                        chop_swap,
  // Gain codes and decoded gains
  output logic [acgc_pkg::CODE_W-1:0]      ch_one_gain_code,
  output logic [acgc_pkg::CODE_W-1:0]      ch_zero_gain_code,
  output logic [acgc_pkg::GAIN_W-1:0]      ch_one_gain,
  output logic [acgc_pkg::GAIN_W-1:0]      ch_zero_gain,
  // Chop control
  output logic [acgc_pkg::DLY_W-1:0]       chop_settle_delay,
  output logic [acgc_pkg::PER_W-1:0]       chop_settle_periods,
  output logic                             chop_enable,
  output logic                             chop_settling,
  output logic                             chop_meas_resume,
  // Current-detect control
  output logic                             detect_all_channels,
  output logic [acgc_pkg::CODE_W-1:0]      detect_exceed_count,
  output logic [acgc_pkg::NUM_W-1:0]       detect_exceed_num,
  output logic [acgc_pkg::CODE_W-1:0]      detect_measure_length,
  output logic [acgc_pkg::LEN_W-1:0]       detect_measure_periods,
  output logic                             detect_mode_enable
);

  // Offsets need four address bits
  if (ADDR_W < acgc_pkg::MIN_AW) begin : g_bad_aw
    $error("acgc_cfg_regs: ADDR_W too small for the register map");
  end

  localparam int unsigned CH_ZERO = 0;
  localparam int unsigned CH_ONE  = 1;

  // Whole bank state in one word
  typedef struct packed {
    logic [acgc_pkg::DATA_W-1:0]                       gain_w;
    logic [acgc_pkg::DATA_W-1:0]                       rsvd_w;
    logic [acgc_pkg::DATA_W-1:0]                       cfg_w;
    logic [acgc_pkg::DATA_W-1:0]                       rdata;
    logic [acgc_pkg::NUM_CH-1:0][acgc_pkg::GAIN_W-1:0] gain;
    logic [acgc_pkg::PER_W-1:0]                        dly_per;
    logic [acgc_pkg::NUM_W-1:0]                        num;
    logic [acgc_pkg::LEN_W-1:0]                        len;
  } acgc_bank_s;

  acgc_bank_s s_q;
  acgc_bank_s s_d;

  // Reset image of the bank
  localparam acgc_bank_s BANK_RST = '{
    gain_w:  acgc_pkg::RST_GAIN,
    rsvd_w:  acgc_pkg::RST_RSVD,
    cfg_w:   acgc_pkg::RST_CFG,
    rdata:   acgc_pkg::RD_ZERO,
    gain:    {acgc_pkg::GAIN_BASE, acgc_pkg::GAIN_BASE},
    dly_per: acgc_pkg::DLY_BASE << acgc_pkg::RST_CFG[acgc_pkg::DLY_LSB +: acgc_pkg::DLY_W],
    num:     acgc_pkg::NUM_BASE,
    len:     acgc_pkg::LEN_TAB[0]
  };

  // Address matches, widened to the port
  logic hit_gain;
  logic hit_rsvd;
  logic hit_cfg;

  assign hit_gain = (reg_addr == ADDR_W'(acgc_pkg::OFS_GAIN));
  assign hit_rsvd = (reg_addr == ADDR_W'(acgc_pkg::OFS_RSVD));
  assign hit_cfg  = (reg_addr == ADDR_W'(acgc_pkg::OFS_CFG));

  // Field codes handed to the decoder
  acgc_field_if fld ();

  for (genvar ch = 0; ch < acgc_pkg::NUM_CH; ch++) begin : g_code
    assign fld.gain_code[ch] =
      s_q.gain_w[acgc_pkg::GAIN0_LSB + ch*acgc_pkg::GAIN_STEP +: acgc_pkg::CODE_W];
  end

  assign fld.dly_code = s_q.cfg_w[acgc_pkg::DLY_LSB +: acgc_pkg::DLY_W];
  assign fld.num_code = s_q.cfg_w[acgc_pkg::NUM_LSB +: acgc_pkg::CODE_W];
  assign fld.len_code = s_q.cfg_w[acgc_pkg::LEN_LSB +: acgc_pkg::CODE_W];

  acgc_field_dec u_dec (
    .fld (fld.dec)
  );

  // Register writes, read return and decoded field capture
  always_comb begin
    s_d       = s_q;
    s_d.rdata = acgc_pkg::RD_ZERO;

    // Write decode; reserved bits are stored as written
    if (reg_wr) begin
      if (hit_gain) begin
        s_d.gain_w = reg_wdata;
      end else if (hit_rsvd) begin
        s_d.rsvd_w = reg_wdata;
      end else if (hit_cfg) begin
        s_d.cfg_w = reg_wdata;
      end
    end

    // Read decode; unmapped offsets return zero
    if (reg_rd) begin
      if (hit_gain) begin
        s_d.rdata = s_q.gain_w;
      end else if (hit_rsvd) begin
        s_d.rdata = s_q.rsvd_w;
      end else if (hit_cfg) begin
        s_d.rdata = s_q.cfg_w;
      end else begin
        s_d.rdata = acgc_pkg::RD_ZERO;
      end
    end

    // Decoded values trail their codes by one cycle to keep outputs registered
    s_d.gain    = fld.gain;
    s_d.dly_per = fld.dly_periods;
    s_d.num     = fld.num;
    s_d.len     = fld.len;
  end

  // Bank register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= BANK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Chop settle sequencer runs from the stored enable and decoded delay
  logic settle_busy;
  logic settle_done;

  acgc_chop_settle u_settle (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .chop_en     (s_q.cfg_w[acgc_pkg::CHOP_BIT]),
    .periods     (s_q.dly_per),
    .mod_tick    (mod_tick),
    .chop_swap   (chop_swap),
    .settling    (settle_busy),
    .meas_resume (settle_done)
  );

  // Read data stands only in the cycle after the read strobe
  assign reg_rdata = s_q.rdata;

  // Gain outputs
  assign ch_one_gain_code  =
    s_q.gain_w[acgc_pkg::GAIN0_LSB + CH_ONE*acgc_pkg::GAIN_STEP +: acgc_pkg::CODE_W];
  assign ch_zero_gain_code =
    s_q.gain_w[acgc_pkg::GAIN0_LSB + CH_ZERO*acgc_pkg::GAIN_STEP +: acgc_pkg::CODE_W];
  assign ch_one_gain  = s_q.gain[CH_ONE];
  assign ch_zero_gain = s_q.gain[CH_ZERO];

  // Chop outputs
  assign chop_settle_delay   = s_q.cfg_w[acgc_pkg::DLY_LSB +: acgc_pkg::DLY_W];
  assign chop_settle_periods = s_q.dly_per;
  assign chop_enable         = s_q.cfg_w[acgc_pkg::CHOP_BIT];
  assign chop_settling       = settle_busy;
  assign chop_meas_resume    = settle_done;

  // Current-detect outputs
  assign detect_all_channels    = s_q.cfg_w[acgc_pkg::ALLCH_BIT];
  assign detect_exceed_count    = s_q.cfg_w[acgc_pkg::NUM_LSB +: acgc_pkg::CODE_W];
  assign detect_exceed_num      = s_q.num;
  assign detect_measure_length  = s_q.cfg_w[acgc_pkg::LEN_LSB +: acgc_pkg::CODE_W];
  assign detect_measure_periods = s_q.len;
  assign detect_mode_enable     = s_q.cfg_w[acgc_pkg::CDEN_BIT];

endmodule : acgc_cfg_regs
`default_nettype wire

// File: dv/acgc_cfg_regs_checker.sv
// Concurrent property checker for the gain and chop configuration bank
`timescale 1ns/1ns
`default_nettype none
module acgc_cfg_regs_checker #(
  parameter int unsigned ADDR_W = 4
) (
  input wire logic              ref_clk,
  input wire logic              srst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [15:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [15:0]       reg_rdata,
  input wire logic              chop_swap,
  input wire logic [2:0]        ch_one_gain_code,
  input wire logic [2:0]        ch_zero_gain_code,
  input wire logic [7:0]        ch_one_gain,
  input wire logic [7:0]        ch_zero_gain,
  input wire logic [3:0]        chop_settle_delay,
  input wire logic [16:0]       chop_settle_periods,
  input wire logic              chop_enable,
  input wire logic              chop_settling,
  input wire logic              chop_meas_resume,
  input wire logic              detect_all_channels,
  input wire logic [2:0]        detect_exceed_count,
  input wire logic [7:0]        detect_exceed_num,
  input wire logic [2:0]        detect_measure_length,
  input wire logic [11:0]       detect_measure_periods,
  input wire logic              detect_mode_enable
);
  // Own copy of the length table, index 0 is the shortest
  localparam logic [7:0][11:0] LENS = {12'he00, 12'ha00, 12'h700, 12'h500,
                                       12'h300, 12'h200, 12'h100, 12'h080};

  // Single domain, so clock and reset are stated once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_rdata_idle : assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  a_gain_write : assert property (
    reg_wr && reg_addr == 4'h4 |=>
    {ch_one_gain_code, ch_zero_gain_code} == {$past(reg_wdata[6:4]), $past(reg_wdata[2:0])})
    else $error("gain codes do not follow write");
  a_cfg_write : assert property (
    reg_wr && reg_addr == 4'h6 |=>
    {chop_settle_delay, chop_enable, detect_all_channels, detect_exceed_count,
     detect_measure_length, detect_mode_enable} == $past(reg_wdata[12:0]))
    else $error("config fields do not follow write");
  a_cfg_read : assert property (
    reg_rd && reg_addr == 4'h6 |=>
    reg_rdata[12:0] == {chop_settle_delay, chop_enable, detect_all_channels,
                        detect_exceed_count, detect_measure_length, detect_mode_enable})
    else $error("config readback differs from fields");
  // Decodes lag their codes; the cycle after a reset edge has no valid past code
  a_gain_decode : assert property (
    !$past(srst) |-> (ch_one_gain == (8'h01 << $past(ch_one_gain_code))) &&
                     (ch_zero_gain == (8'h01 << $past(ch_zero_gain_code))))
    else $error("gain decode wrong");
  a_count_decode : assert property (
    !$past(srst) |-> (chop_settle_periods == (17'h00002 << $past(chop_settle_delay))) &&
                     (detect_exceed_num == (8'h01 << $past(detect_exceed_count))))
    else $error("delay or count decode wrong");
  a_len_decode : assert property (
    !$past(srst) |-> detect_measure_periods == LENS[$past(detect_measure_length)])
    else $error("measure length decode wrong");
  a_settle_start : assert property (chop_swap && chop_enable |=> chop_settling)
    else $error("settle wait did not start");
  a_resume_end : assert property (
    chop_meas_resume |-> (!chop_settling && $past(chop_settling)) ##1 !chop_meas_resume)
    else $error("resume pulse malformed");
  a_chop_off : assert property (!chop_enable [*2] |-> !chop_settling)
    else $error("settling while chop disabled");
endmodule : acgc_cfg_regs_checker

bind acgc_cfg_regs acgc_cfg_regs_checker #(.ADDR_W(ADDR_W)) chk_u (
  .ref_clk                (ref_clk),
  .srst                   (srst),
  .reg_addr               (reg_addr),
  .reg_wdata              (reg_wdata),
  .reg_wr                 (reg_wr),
  .reg_rd                 (reg_rd),
  .reg_rdata              (reg_rdata),
  .chop_swap              (chop_swap),
  .ch_one_gain_code       (ch_one_gain_code),
  .ch_zero_gain_code      (ch_zero_gain_code),
  .ch_one_gain            (ch_one_gain),
  .ch_zero_gain           (ch_zero_gain),
  .chop_settle_delay      (chop_settle_delay),
  .chop_settle_periods    (chop_settle_periods),
  .chop_enable            (chop_enable),
  .chop_settling          (chop_settling),
  .chop_meas_resume       (chop_meas_resume),
  .detect_all_channels    (detect_all_channels),
  .detect_exceed_count    (detect_exceed_count),
  .detect_exceed_num      (detect_exceed_num),
  .detect_measure_length  (detect_measure_length),
  .detect_measure_periods (detect_measure_periods),
  .detect_mode_enable     (detect_mode_enable)
);
`default_nettype wire

// File: dv/acgc_cfg_regs_tb.sv
// Self-checking testbench for the gain and chop configuration bank
`timescale 1ns/1ns
`default_nettype none
module acgc_cfg_regs_tb;
  logic        ref_clk, srst, reg_wr, reg_rd, mod_tick, chop_swap;
  logic [3:0]  reg_addr, chop_settle_delay;
  logic [15:0] reg_wdata, reg_rdata;
  logic [2:0]  ch_one_gain_code, ch_zero_gain_code, detect_exceed_count, detect_measure_length;
  logic [7:0]  ch_one_gain, ch_zero_gain, detect_exceed_num;
  logic [16:0] chop_settle_periods;
  logic [11:0] detect_measure_periods;
  logic        chop_enable, chop_settling, chop_meas_resume, detect_all_channels;
  logic        detect_mode_enable;
  int          failures, num_checks;
  logic [11:0] lens [8] = '{12'h080, 12'h100, 12'h200, 12'h300,
                            12'h500, 12'h700, 12'ha00, 12'he00};

  acgc_cfg_regs #(.ADDR_W(4)) dut_u (
    .ref_clk                (ref_clk),
    .srst                   (srst),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .reg_rdata              (reg_rdata),
    .mod_tick               (mod_tick),
    .chop_swap              (chop_swap),
    .ch_one_gain_code       (ch_one_gain_code),
    .ch_zero_gain_code      (ch_zero_gain_code),
    .ch_one_gain            (ch_one_gain),
    .ch_zero_gain           (ch_zero_gain),
    .chop_settle_delay      (chop_settle_delay),
    .chop_settle_periods    (chop_settle_periods),
    .chop_enable            (chop_enable),
    .chop_settling          (chop_settling),
    .chop_meas_resume       (chop_meas_resume),
    .detect_all_channels    (detect_all_channels),
    .detect_exceed_count    (detect_exceed_count),
    .detect_exceed_num      (detect_exceed_num),
    .detect_measure_length  (detect_measure_length),
    .detect_measure_periods (detect_measure_periods),
    .detect_mode_enable     (detect_mode_enable)
  );

  // Free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One-cycle strobes; a gap cycle follows so strobes never double-drive
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", {1'b0, e}, {1'b0, reg_rdata});
  endtask : rd

  task automatic t_reset();
    rd(4'h4, 16'h0000);
    rd(4'h5, 16'h0000);
    rd(4'h6, 16'h0600);
    chk("gains", 17'h00101, {1'b0, ch_one_gain, ch_zero_gain});
    chk("chop_settle_periods", 17'h00010, chop_settle_periods);
    chk("detect_exceed_num", 17'h00001, {9'h0, detect_exceed_num});
    chk("detect_measure_periods", 17'h00080, {5'h0, detect_measure_periods});
    chk("enables", 17'h0, {14'h0, chop_enable, detect_all_channels, detect_mode_enable});
  endtask : t_reset

  // Every gain code on both channels, in opposite order
  task automatic t_gain();
    logic [15:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {9'h0, 3'(7 - i), 1'b0, 3'(i)};
      wr(4'h4, d);
      @(posedge ref_clk);
      #1;
      chk("ch_zero_gain", 17'h1 << i, {9'h0, ch_zero_gain});
      chk("ch_one_gain", 17'h1 << (7 - i), {9'h0, ch_one_gain});
      rd(4'h4, d);
    end
  endtask : t_gain

  // Every delay code, with count, length and flags varied alongside
  task automatic t_cfg();
    logic [15:0] d;
    for (int i = 0; i < 16; i++) begin
      d = {3'h0, 4'(i), 1'b0, i[0], 3'(i), 3'(i) ^ 3'h5, i[1]};
      wr(4'h6, d);
      @(posedge ref_clk);
      #1;
      chk("chop_settle_periods", 17'h2 << i, chop_settle_periods);
      chk("detect_exceed_num", 17'h1 << d[6:4], {9'h0, detect_exceed_num});
      chk("detect_measure_periods", 17'(lens[d[3:1]]), {5'h0, detect_measure_periods});
      chk("flags", {15'h0, d[7], d[0]}, {15'h0, detect_all_channels, detect_mode_enable});
      rd(4'h6, d);
    end
  endtask : t_cfg

  // Reserved word takes zeros; unmapped offset ignores writes, reads zero
  task automatic t_rsvd();
    wr(4'h5, 16'h0000);
    rd(4'h5, 16'h0000);
    wr(4'h9, 16'hffff);
    rd(4'h9, 16'h0000);
    rd(4'h4, 16'h0007);
    rd(4'h6, 16'h1ef5);
  endtask : t_rsvd

  // Swap ignored while chop is off, shortest delay of two ticks, then an abort
  task automatic t_chop();
    @(posedge ref_clk);
    chop_swap <= 1'b1;
    @(posedge ref_clk);
    chop_swap <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk("ignored_swap", 17'h0, {16'h0, chop_settling});
    wr(4'h6, 16'h0100);
    @(posedge ref_clk);
    chop_swap <= 1'b1;
    @(posedge ref_clk);
    chop_swap <= 1'b0;
    mod_tick <= 1'b1;
    #1;
    chk("chop_settling", 17'h1, {16'h0, chop_settling});
    @(posedge ref_clk);
    #1;
    chk("early_resume", 17'h0, {16'h0, chop_meas_resume});
    @(posedge ref_clk);
    mod_tick <= 1'b0;
    #1;
    chk("resume_settling", 17'h2, {15'h0, chop_meas_resume, chop_settling});
    @(posedge ref_clk);
    chop_swap <= 1'b1;
    @(posedge ref_clk);
    chop_swap <= 1'b0;
    wr(4'h6, 16'h0000);
    @(posedge ref_clk);
    #1;
    chk("aborted_settling", 17'h0, {15'h0, chop_meas_resume, chop_settling});
  endtask : t_chop

  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // Main sequence, with a second reset in mid-run
  initial begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    mod_tick = 1'b0;
    chop_swap = 1'b0;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset();
    t_gain();
    t_cfg();
    t_rsvd();
    t_chop();
    @(posedge ref_clk);
    srst <= 1'b1;
    @(posedge ref_clk);
    srst <= 1'b0;
    t_reset();
    complete_run();
  end

  // Watchdog, far beyond the under two hundred cycles the tests need
  initial begin
    #200000;
    failures++;
    complete_run();
  end
endmodule : acgc_cfg_regs_tb
`default_nettype wire
